//--- rtl/tmr_pkg.sv
// Package with register map, field positions and reset values of the 16-bit timer
package tmr_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] TMR_IDX_CTRL_TWO = 6'h31;
  localparam logic [5:0] TMR_IDX_CTRL_ONE = 6'h32;
  localparam logic [5:0] TMR_IDX_FLAGS    = 6'h33;
  localparam logic [5:0] TMR_IDX_CAP_A_HI = 6'h34;
  localparam logic [5:0] TMR_IDX_CAP_A_LO = 6'h35;
  localparam logic [5:0] TMR_IDX_CMP_A_HI = 6'h36;
  localparam logic [5:0] TMR_IDX_CMP_A_LO = 6'h37;
  localparam logic [5:0] TMR_IDX_CNT_HI   = 6'h38;
  localparam logic [5:0] TMR_IDX_CNT_LO   = 6'h39;
  localparam logic [5:0] TMR_IDX_ALT_HI   = 6'h3A;
  localparam logic [5:0] TMR_IDX_ALT_LO   = 6'h3B;
  localparam logic [5:0] TMR_IDX_CAP_B_HI = 6'h3C;
  localparam logic [5:0] TMR_IDX_CAP_B_LO = 6'h3D;
  localparam logic [5:0] TMR_IDX_CMP_B_HI = 6'h3E;
  localparam logic [5:0] TMR_IDX_CMP_B_LO = 6'h3F;

  // Control one fields
  localparam int TMR_C1_CAP_IE  = 7;
  localparam int TMR_C1_CMP_IE  = 6;
  localparam int TMR_C1_OVF_IE  = 5;
  localparam int TMR_C1_FRC_B   = 4;
  localparam int TMR_C1_FRC_A   = 3;
  localparam int TMR_C1_LVL_B   = 2;
  localparam int TMR_C1_EDGE_A  = 1;
  localparam int TMR_C1_LVL_A   = 0;
  // Control two fields
  localparam int TMR_C2_PIN_A   = 7;
  localparam int TMR_C2_PIN_B   = 6;
  localparam int TMR_C2_ONE_P   = 5;
  localparam int TMR_C2_PWM     = 4;
  localparam int TMR_C2_CLK_HI  = 3;
  localparam int TMR_C2_CLK_LO  = 2;
  localparam int TMR_C2_EDGE_B  = 1;
  localparam int TMR_C2_EXT_EDG = 0;

  // Flag vector index k sits at status bit 7-k
  localparam int TMR_NFLAG      = 5;
  localparam int TMR_F_CAP_A    = 0;
  localparam int TMR_F_CMP_A    = 1;
  localparam int TMR_F_OVF      = 2;
  localparam int TMR_F_CAP_B    = 3;
  localparam int TMR_F_CMP_B    = 4;

  // Reset values and fixed counts
  localparam logic [7:0]  TMR_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TMR_CMP_HI_RST = 8'h80;
  localparam logic [7:0]  TMR_CMP_LO_RST = 8'h00;
  localparam logic [15:0] TMR_CNT_RST    = 16'hFFFC;
  localparam logic [15:0] TMR_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TMR_OPM_CAP    = 16'hFFFD;
  localparam logic [2:0]  TMR_PRE_DIV2   = 3'h1;
  localparam logic [2:0]  TMR_PRE_DIV4   = 3'h3;
  localparam logic [2:0]  TMR_PRE_DIV8   = 3'h7;

  typedef enum logic [1:0] {
    TMR_CLK_DIV4 = 2'b00,
    TMR_CLK_DIV2 = 2'b01,
    TMR_CLK_DIV8 = 2'b10,
    TMR_CLK_EXT  = 2'b11
  } tmr_clk_sel_t;
endpackage

//--- rtl/tmr_core.sv
// 16-bit timer with two captures, two compares, one-pulse and PWM modes, APB registers
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmr_core
  import tmr_pkg::*;
#(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        halt_mode,
  input  wire logic        cpu_irq_mask,
  output logic             timer_irq,
  input  wire logic        cap_a_pin,
  input  wire logic        cap_b_pin,
  input  wire logic        ext_clk_pin,
  output logic             cmp_a_pin,
  output logic             cmp_a_oe,
  output logic             cmp_b_pin,
  output logic             cmp_b_oe
);

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        irq_q;
  logic [7:0]  ctrl_one_q;
  logic [7:0]  ctrl_two_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic        inh_a_q;
  logic        inh_b_q;
  logic [15:0] cnt_q;
  logic [15:0] cap_a_q;
  logic [15:0] cap_b_q;
  logic [2:0]  pre_q;
  logic [TMR_NFLAG-1:0] flag_q;
  logic [TMR_NFLAG-1:0] arm_q;
  logic [TMR_NFLAG-1:0] flag_set;
  logic [TMR_NFLAG-1:0] low_acc;
  logic        pin_a_q;
  logic        pin_b_q;
  logic        halt_q;
  logic        hold_a_q;
  logic        hold_b_q;
  logic [2:0]  cap_a_sy_q;
  logic [2:0]  cap_b_sy_q;
  logic [2:0]  ext_sy_q;

  // Bus decode
  logic        acc_done;
  logic        wr_done;
  logic        rd_done;
  logic [5:0]  idx;
  logic        idx_ok;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;
  assign acc_done = psel & penable & pready_q;
  assign wr_done  = acc_done & pwrite & idx_ok;
  assign rd_done  = acc_done & ~pwrite & idx_ok;
  assign idx      = paddr[7:2];
  assign wbyte    = pwdata[7:0];
  assign idx_ok   = (paddr[1:0] == 2'b00) && (idx >= TMR_IDX_CTRL_TWO) &&
                    (idx <= TMR_IDX_CMP_B_LO);

  // Modes; PWM wins when both mode bits are set
  logic pwm_on;
  logic opm_on;
  logic lvl_a;
  logic lvl_b;
  assign pwm_on = ctrl_two_q[TMR_C2_PWM];
  assign opm_on = ctrl_two_q[TMR_C2_ONE_P] & ~pwm_on;
  assign lvl_a  = ctrl_one_q[TMR_C1_LVL_A];
  assign lvl_b  = ctrl_one_q[TMR_C1_LVL_B];

  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_a_sy_q <= 3'h0;
      cap_b_sy_q <= 3'h0;
      ext_sy_q   <= 3'h0;
    end else begin
      cap_a_sy_q <= {cap_a_sy_q[1:0], cap_a_pin};
      cap_b_sy_q <= {cap_b_sy_q[1:0], cap_b_pin};
      ext_sy_q   <= {ext_sy_q[1:0], ext_clk_pin};
    end
  end

  logic edge_a;
  logic edge_b;
  logic edge_ext;
  assign edge_a = ctrl_one_q[TMR_C1_EDGE_A] ? (cap_a_sy_q[1] & ~cap_a_sy_q[2]) :
                                              (~cap_a_sy_q[1] & cap_a_sy_q[2]);
  assign edge_b = ctrl_two_q[TMR_C2_EDGE_B] ? (cap_b_sy_q[1] & ~cap_b_sy_q[2]) :
                                              (~cap_b_sy_q[1] & cap_b_sy_q[2]);
  assign edge_ext = ctrl_two_q[TMR_C2_EXT_EDG] ? (ext_sy_q[1] & ~ext_sy_q[2]) :
                                                 (~ext_sy_q[1] & ext_sy_q[2]);

  // Prescaler runs free; slower rates are one-cycle enables
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  logic tick;
  always_comb begin
    case (tmr_clk_sel_t'(ctrl_two_q[TMR_C2_CLK_HI:TMR_C2_CLK_LO]))
      TMR_CLK_DIV4: tick = (pre_q[1:0] == TMR_PRE_DIV4[1:0]);
      TMR_CLK_DIV2: tick = (pre_q[0] == TMR_PRE_DIV2[0]);
      TMR_CLK_DIV8: tick = (pre_q == TMR_PRE_DIV8);
      TMR_CLK_EXT:  tick = HAS_EXT_CLK & edge_ext;
      default:      tick = 1'b0;
    endcase
    // frozen in halt; wait has no effect here
    tick = tick & ~halt_mode;
  end

  // Events
  logic match_a;
  logic match_b;
  logic pwm_per;
  logic opm_trig;
  logic ovf_evt;
  logic halt_exit;
  logic cap_a_evt;
  logic cap_b_evt;
  logic cnt_wr;
  // compares run whatever the pin enables say
  assign match_a   = tick & ~inh_a_q & (cnt_q == cmp_a_q);
  assign match_b   = tick & ~inh_b_q & (cnt_q == cmp_b_q);
  assign pwm_per   = pwm_on & match_b;
  // pin a edge triggers the pulse
  assign opm_trig  = opm_on & edge_a & ~halt_mode;
  assign ovf_evt   = tick & (cnt_q == TMR_CNT_MAX) & ~pwm_per;
  assign halt_exit = halt_q & ~halt_mode;
  // Pin a is disconnected from capture in both waveform modes
  assign cap_a_evt = (edge_a & ~halt_mode & ~pwm_on & ~opm_on) |
                     (halt_exit & hold_a_q);
  assign cap_b_evt = (edge_b & ~halt_mode) | (halt_exit & hold_b_q);
  assign cnt_wr    = wr_done & ((idx == TMR_IDX_CNT_LO) | (idx == TMR_IDX_ALT_LO));

  // counter with reset value and low-byte write reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= TMR_CNT_RST;
    end else if (cnt_wr | opm_trig | pwm_per) begin
      cnt_q <= TMR_CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // capture edges during halt are held until exit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_q   <= 1'b0;
      hold_a_q <= 1'b0;
      hold_b_q <= 1'b0;
    end else begin
      halt_q <= halt_mode;
      if (halt_exit) begin
        hold_a_q <= 1'b0;
        hold_b_q <= 1'b0;
      end else if (halt_mode) begin
        hold_a_q <= hold_a_q | (edge_a & ~pwm_on & ~opm_on);
        hold_b_q <= hold_b_q | edge_b;
      end
    end
  end

  // Capture registers; undefined after reset, cleared here for determinism
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_a_q <= 16'h0000;
      cap_b_q <= 16'h0000;
    end else begin
      if (opm_trig) begin
        cap_a_q <= TMR_OPM_CAP;
      end else if (cap_a_evt) begin
        cap_a_q <= cnt_q;
      end
      if (cap_b_evt) begin
        cap_b_q <= cnt_q;
      end
    end
  end

  // Flag sources
  // capture a, pulse trigger or PWM period
  assign flag_set[TMR_F_CAP_A] = cap_a_evt | opm_trig | pwm_per;
  // compare flags are silent in PWM, flag a also in single-pulse
  assign flag_set[TMR_F_CMP_A] = match_a & ~pwm_on & ~opm_on;
  assign flag_set[TMR_F_CMP_B] = match_b & ~pwm_on;
  assign flag_set[TMR_F_OVF]   = ovf_evt;
  assign flag_set[TMR_F_CAP_B] = cap_b_evt;

  // Low-byte accesses that finish the two-step clear; alternate counter excluded
  assign low_acc[TMR_F_CAP_A] = acc_done & (idx == TMR_IDX_CAP_A_LO);
  assign low_acc[TMR_F_CMP_A] = acc_done & (idx == TMR_IDX_CMP_A_LO);
  assign low_acc[TMR_F_OVF]   = acc_done & (idx == TMR_IDX_CNT_LO);
  assign low_acc[TMR_F_CAP_B] = acc_done & (idx == TMR_IDX_CAP_B_LO);
  assign low_acc[TMR_F_CMP_B] = acc_done & (idx == TMR_IDX_CMP_B_LO);

  logic stat_rd;
  assign stat_rd = rd_done & (idx == TMR_IDX_FLAGS);

  // Set beats clear so an event in the clearing cycle survives
  for (genvar g = 0; g < TMR_NFLAG; g++) begin : g_flag
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        flag_q[g] <= 1'b0;
        arm_q[g]  <= 1'b0;
      end else begin
        if (flag_set[g]) begin
          flag_q[g] <= 1'b1;
        end else if (low_acc[g] & arm_q[g]) begin
          flag_q[g] <= 1'b0;
        end
        if (stat_rd) begin
          arm_q[g] <= flag_q[g];
        end else if (low_acc[g]) begin
          arm_q[g] <= 1'b0;
        end
      end
    end
  end

  // Control and compare registers; high write stalls compare until low write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_q <= TMR_CTRL_RST;
      ctrl_two_q <= TMR_CTRL_RST;
      cmp_a_q    <= {TMR_CMP_HI_RST, TMR_CMP_LO_RST};
      cmp_b_q    <= {TMR_CMP_HI_RST, TMR_CMP_LO_RST};
      inh_a_q    <= 1'b0;
      inh_b_q    <= 1'b0;
    end else if (wr_done) begin
      case (idx)
        TMR_IDX_CTRL_ONE: ctrl_one_q <= wbyte;
        TMR_IDX_CTRL_TWO: ctrl_two_q <= wbyte;
        TMR_IDX_CMP_A_HI: begin
          cmp_a_q[15:8] <= wbyte;
          inh_a_q       <= 1'b1;
        end
        TMR_IDX_CMP_A_LO: begin
          cmp_a_q[7:0] <= wbyte;
          inh_a_q      <= 1'b0;
        end
        TMR_IDX_CMP_B_HI: begin
          cmp_b_q[15:8] <= wbyte;
          inh_b_q       <= 1'b1;
        end
        TMR_IDX_CMP_B_LO: begin
          cmp_b_q[7:0] <= wbyte;
          inh_b_q      <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Force requests act on the write itself, not on the stored bit
  logic frc_a;
  logic frc_b;
  logic ctrl_one_wr;
  assign ctrl_one_wr = wr_done & (idx == TMR_IDX_CTRL_ONE);
  assign frc_a = ctrl_one_wr & wbyte[TMR_C1_FRC_A] & ~pwm_on & ~opm_on;
  assign frc_b = ctrl_one_wr & wbyte[TMR_C1_FRC_B] & ~pwm_on & ~opm_on;

  // Pin a level; only moves while the pin is routed out
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_a_q <= 1'b0;
    end else if (ctrl_two_q[TMR_C2_PIN_A]) begin
      if (pwm_on) begin
        // period edge takes level_b, width edge takes level_a
        if (pwm_per) begin
          pin_a_q <= lvl_b;
        end else if (match_a) begin
          pin_a_q <= lvl_a;
        end
      end else if (opm_on) begin
        // pulse starts with level_b, ends with level_a
        if (opm_trig) begin
          pin_a_q <= lvl_b;
        end else if (match_a) begin
          pin_a_q <= lvl_a;
        end
      end else if (frc_a) begin
        pin_a_q <= wbyte[TMR_C1_LVL_A];
      end else if (match_a) begin
        pin_a_q <= lvl_a;
      end
    end
  end

  // Pin b level; level_b belongs to pin a in both waveform modes
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_b_q <= 1'b0;
    end else if (ctrl_two_q[TMR_C2_PIN_B] & ~pwm_on & ~opm_on) begin
      if (frc_b) begin
        pin_b_q <= wbyte[TMR_C1_LVL_B];
      end else if (match_b) begin
        pin_b_q <= lvl_b;
      end
    end
  end

  // Shared interrupt line
  logic irq_d;
  always_comb begin
    irq_d = 1'b0;
    if (ctrl_one_q[TMR_C1_CAP_IE] & (flag_q[TMR_F_CAP_A] | flag_q[TMR_F_CAP_B])) begin
      irq_d = 1'b1;
    end
    if (ctrl_one_q[TMR_C1_CMP_IE] & (flag_q[TMR_F_CMP_A] | flag_q[TMR_F_CMP_B])) begin
      irq_d = 1'b1;
    end
    if (ctrl_one_q[TMR_C1_OVF_IE] & flag_q[TMR_F_OVF]) begin
      irq_d = 1'b1;
    end
    // masked by CPU, never raised in halt, free to wake from wait
    irq_d = irq_d & ~cpu_irq_mask & ~halt_mode;
  end

  // Read mux; status low bits are zero
  always_comb begin
    case (idx)
      TMR_IDX_CTRL_ONE: rd_byte = ctrl_one_q;
      TMR_IDX_CTRL_TWO: rd_byte = ctrl_two_q;
      TMR_IDX_FLAGS:    rd_byte = {flag_q[0], flag_q[1], flag_q[2], flag_q[3], flag_q[4],
                                   3'h0};
      TMR_IDX_CAP_A_HI: rd_byte = cap_a_q[15:8];
      TMR_IDX_CAP_A_LO: rd_byte = cap_a_q[7:0];
      TMR_IDX_CMP_A_HI: rd_byte = cmp_a_q[15:8];
      TMR_IDX_CMP_A_LO: rd_byte = cmp_a_q[7:0];
      TMR_IDX_CNT_HI:   rd_byte = cnt_q[15:8];
      TMR_IDX_CNT_LO:   rd_byte = cnt_q[7:0];
      TMR_IDX_ALT_HI:   rd_byte = cnt_q[15:8];
      TMR_IDX_ALT_LO:   rd_byte = cnt_q[7:0];
      TMR_IDX_CAP_B_HI: rd_byte = cap_b_q[15:8];
      TMR_IDX_CAP_B_LO: rd_byte = cap_b_q[7:0];
      TMR_IDX_CMP_B_HI: rd_byte = cmp_b_q[15:8];
      TMR_IDX_CMP_B_LO: rd_byte = cmp_b_q[7:0];
      default:          rd_byte = 8'h00;
    endcase
  end

  // APB slave: one wait state, data and error captured with ready
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel & penable & ~pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= (~pwrite & idx_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_q <= ~idx_ok;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign timer_irq = irq_q;
  assign cmp_a_pin = pin_a_q;
  assign cmp_b_pin = pin_b_q;
  assign cmp_a_oe  = ctrl_two_q[TMR_C2_PIN_A];
  assign cmp_b_oe  = ctrl_two_q[TMR_C2_PIN_B];

endmodule
`default_nettype wire

//--- bench/tmr_core_monitor.sv
// Checker for the timer's bus timing, interrupt gating and compare pin a routing
`timescale 1ns/1ps
`default_nettype none
module tmr_core_monitor (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        halt_mode,
  input wire logic        cpu_irq_mask,
  input wire logic        timer_irq,
  input wire logic        cmp_a_pin,
  input wire logic        cmp_a_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;

  a_wait_state: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  a_flags_low: assert property (pready && !pwrite && paddr == 8'hCC |-> prdata[2:0] == 3'h0)
    else $error("unused flag bits not zero");
  a_halt_quiet: assert property (halt_mode |=> !timer_irq)
    else $error("interrupt during halt");
  a_mask_quiet: assert property (cpu_irq_mask |=> !timer_irq)
    else $error("interrupt while masked");
  a_irq_off: assert property (
    wr_ok && paddr == 8'hC8 && pwdata[7:5] == 3'h0 |-> ##2 !timer_irq)
    else $error("interrupt with all enables clear");
  a_route_a: assert property (
    wr_ok && paddr == 8'hC4 |-> ##2 cmp_a_oe == $past(pwdata[7], 2))
    else $error("pin enable not routed");
  a_gate_a: assert property ($changed(cmp_a_pin) |-> cmp_a_oe || $past(cmp_a_oe))
    else $error("pin moved while not enabled");
endmodule

bind tmr_core tmr_core_monitor mon_u (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask),
  .timer_irq(timer_irq), .cmp_a_pin(cmp_a_pin), .cmp_a_oe(cmp_a_oe)
);
`default_nettype wire

//--- bench/tmr_pin_model.sv
// Model of the pins around the timer: capture inputs and external count clock
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input  wire logic core_clk,
  output var logic  cap_a_pin,
  output var logic  cap_b_pin,
  output var logic  ext_clk_pin
);
  initial begin
    cap_a_pin = 1'b0;
    cap_b_pin = 1'b0;
    ext_clk_pin = 1'b0;
  end
  // Each level is held long enough to pass the synchroniser and edge detect
  task automatic drive(input int k, input logic v);
    @(posedge core_clk);
    case (k)
      0: cap_a_pin <= v;
      1: cap_b_pin <= v;
      default: ext_clk_pin <= v;
    endcase
    repeat (6) @(posedge core_clk);
  endtask
  // one rising edge per count, clock stands still between bursts
  task automatic tick(input int n);
    repeat (n) begin
      drive(2, 1'b1);
      drive(2, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/sixteen_bit_timer_ctrl_bench.sv
// Self-checking bench for the 16-bit timer: registers, counting, flags, pins and modes
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_ctrl_bench;
  logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rq;
  logic [31:0] pwdata, prdata;
  logic        halt_mode, cpu_irq_mask, timer_irq, re;
  logic        cap_a_pin, cap_b_pin, ext_clk_pin, cmp_a_pin, cmp_a_oe, cmp_b_pin, cmp_b_oe;
  int          cnt, fail_count, comparisons;
  logic [15:0] rv [7] = '{16'hCC00, 16'hC800, 16'hC400, 16'hD880, 16'hDC00, 16'hF880, 16'hFC00};

  tmr_core dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask),
    .timer_irq(timer_irq), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin),
    .ext_clk_pin(ext_clk_pin), .cmp_a_pin(cmp_a_pin), .cmp_a_oe(cmp_a_oe),
    .cmp_b_pin(cmp_b_pin), .cmp_b_oe(cmp_b_oe)
  );
  tmr_pin_model pins_u (
    .core_clk(core_clk), .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin),
    .ext_clk_pin(ext_clk_pin)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until ready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 16'h1, 16'h0);
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rq);
  endtask

  // Counter model follows every external count edge
  task automatic adv(input int n);
    pins_u.tick(n);
    cnt = (cnt + n) & 16'hFFFF;
  endtask

  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    results();
  end

  initial begin
    {fail_count, comparisons} = '0;
    {reset_n, psel, penable, pwrite, halt_mode, cpu_irq_mask} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hA5DB));
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rv[i]) rd(rv[i][15:8], rv[i][7:0]);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped error", 16'h1, re);
    apb(1'b1, 8'hC4, 8'hCD);
    rd(8'hCC, 8'h20);
    apb(1'b1, 8'hE4, 8'h00);
    cnt = 16'hFFFC;
    chk("pin b route", 16'h1, cmp_b_oe);
    rd(8'hCC, 8'h00);
    rd(8'hE0, 8'hFF);
    rd(8'hE4, 8'hFC);
    apb(1'b1, 8'hD8, 8'h00);
    apb(1'b1, 8'hDC, 8'h02);
    // Compare b high byte leaves reset as 80; clear it so the match lands low
    apb(1'b1, 8'hF8, 8'h00);
    apb(1'b1, 8'hFC, 8'h03);
    apb(1'b1, 8'hC8, 8'h25);
    adv(1);
    pins_u.drive(2, 1'b1);
    cnt = (cnt + 1) & 16'hFFFF;
    rd(8'hE4, cnt[7:0]);
    pins_u.drive(2, 1'b0);
    rd(8'hE4, cnt[7:0]);
    adv(2);
    rd(8'hCC, 8'h20);
    chk("irq overflow", 16'h1, timer_irq);
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("irq masked", 16'h0, timer_irq);
    cpu_irq_mask <= 1'b0;
    rd(8'hEC, 8'h00);
    rd(8'hCC, 8'h20);
    rd(8'hE4, 8'h00);
    rd(8'hCC, 8'h00);
    adv(4);
    rd(8'hCC, 8'h48);
    chk("pin a", 16'h1, cmp_a_pin);
    chk("pin b", 16'h1, cmp_b_pin);
    chk("irq compare off", 16'h0, timer_irq);
    apb(1'b1, 8'hC8, 8'h65);
    repeat (3) @(posedge core_clk);
    chk("irq compare on", 16'h1, timer_irq);
    rd(8'hDC, 8'h02);
    rd(8'hCC, 8'h08);
    apb(1'b1, 8'hFC, 8'h03);
    rd(8'hCC, 8'h00);
    apb(1'b1, 8'hC8, 8'h18);
    repeat (3) @(posedge core_clk);
    chk("forced a", 16'h0, cmp_a_pin);
    chk("forced b", 16'h0, cmp_b_pin);
    apb(1'b1, 8'hC8, 8'h02);
    pins_u.drive(0, 1'b1);
    adv(1);
    pins_u.drive(0, 1'b0);
    rd(8'hD4, 8'h04);
    rd(8'hCC, 8'h80);
    rd(8'hD4, 8'h04);
    rd(8'hCC, 8'h00);
    pins_u.drive(1, 1'b1);
    rd(8'hCC, 8'h00);
    adv(1);
    pins_u.drive(1, 1'b0);
    rd(8'hCC, 8'h10);
    rd(8'hF4, 8'h06);
    halt_mode <= 1'b1;
    pins_u.tick(2);
    pins_u.drive(1, 1'b1);
    pins_u.drive(1, 1'b0);
    halt_mode <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(8'hE4, 8'h06);
    rd(8'hCC, 8'h10);
    rd(8'hF4, 8'h06);
    adv($urandom_range(12, 1));
    rd(8'hE0, cnt[15:8]);
    rd(8'hE4, cnt[7:0]);
    apb(1'b1, 8'hD8, 8'hFF);
    apb(1'b1, 8'hDC, 8'hFE);
    apb(1'b1, 8'hC8, 8'h06);
    apb(1'b1, 8'hC4, 8'hED);
    pins_u.drive(0, 1'b1);
    rd(8'hD4, 8'hFD);
    chk("pulse start", 16'h1, cmp_a_pin);
    pins_u.tick(3);
    chk("pulse end", 16'h0, cmp_a_pin);
    rd(8'hCC, 8'h80);
    apb(1'b1, 8'hFC, 8'h01);
    apb(1'b1, 8'hC4, 8'hDD);
    pins_u.tick(3);
    rd(8'hE4, 8'hFC);
    chk("pwm level", 16'h1, cmp_a_pin);
    results();
  end
endmodule
`default_nettype wire
